// File: nvm_pkg.sv
// Constants, state codes and widths for the two-wire memory slave.
// Assumes the top module and the bench both import the whole package.
package nvm_pkg;

   localparam int unsigned MEM_AW = 13;
   localparam int unsigned MEM_WORDS = 8192;
   localparam int unsigned HI_W = 5;

   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   localparam logic [12:0] ADDR_RST = 13'h0000;
   localparam logic [12:0] ADDR_STEP = 13'h0001;
   localparam logic [4:0] HI_RST = 5'h00;
   localparam logic [6:0] SHIFT_RST = 7'h00;
   localparam logic [7:0] TX_RST = 8'h00;
   localparam logic [2:0] PIN3_RST = 3'h0;

   typedef enum logic [2:0] {
      ST_ADDR = 3'b000,
      ST_MHI = 3'b001,
      ST_MLO = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_IGNORE = 3'b101
   } nvm_state_t;

endpackage : nvm_pkg

// File: nvm_top.sv
// Two-wire serial slave with an 8192 x 8 byte array behind it.
// Assumes an external pull-up on the data line and a master that owns the clock.
`timescale 1ns/1ps

module nvm_top
   import nvm_pkg::*;
#(
   // Device type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h5
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic [2:0] i_chip_select_pins,
   input wire logic i_write_protect
);

   ////////////////////////////////////////////////////////////////////////////
   // Start and stop detection on the system clock

   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   logic cond_rstn_q;
   wire start_det;
   wire stop_det;
   wire link_rstn;

   // Both lines share one sync depth, so their order is kept
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= i_scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= i_sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // Held in reset from power-on until the first clock
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cond_rstn_q <= 1'b0;
      end else begin
         cond_rstn_q <= ~(start_det | stop_det);
      end
   end

   // Either condition resets the link side except the pin straps and the address latch; the clock is idle-high then
   assign link_rstn = cond_rstn_q;

   ////////////////////////////////////////////////////////////////////////////
   // Link side: pin straps

   logic [2:0] cs_m_q;
   logic [2:0] cs_s_q;
   logic wp_m_q;
   logic wp_s_q;

   always_ff @(posedge i_scl or negedge i_rstn) begin
      if (!i_rstn) begin
         cs_m_q <= PIN3_RST;
         cs_s_q <= PIN3_RST;
         wp_m_q <= 1'b0;
         wp_s_q <= 1'b0;
      end else begin
         cs_m_q <= i_chip_select_pins;
         cs_s_q <= cs_m_q;
         wp_m_q <= i_write_protect;
         wp_s_q <= wp_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link side: bit framing and protocol state

   nvm_state_t st_q;
   logic [3:0] cnt_q;
   logic [6:0] shift_q;
   logic [4:0] hi_q;
   logic [7:0] tx_q;
   logic ack_q;
   logic [12:0] mem_addr_q;
   logic [7:0] mem_q [MEM_WORDS];

   wire [7:0] rx_byte;
   wire byte_end;
   wire ack_slot;
   wire addr_match;
   wire load_addr;
   wire wr_en;
   wire inc_addr;
   wire [3:0] tx_pos;
   wire tx_bit;

   // Shifted in most significant bit first
   assign rx_byte = {shift_q, i_sda};
   assign byte_end = (cnt_q == BIT_LAST);
   assign ack_slot = (cnt_q == BIT_ACK);
   assign addr_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3:1] == cs_s_q);
   assign load_addr = byte_end && (st_q == ST_MLO);
   // Write lands on the eighth rising edge
   assign wr_en = byte_end && (st_q == ST_WDATA) && !wp_s_q;
   assign inc_addr = byte_end && (wr_en || (st_q == ST_RDATA));

   // Sample every incoming bit on the rising edge
   always_ff @(posedge i_scl or negedge link_rstn) begin
      if (!link_rstn) begin
         cnt_q <= BIT_FIRST;
         shift_q <= SHIFT_RST;
      end else begin
         cnt_q <= ack_slot ? BIT_FIRST : cnt_q + 4'h1;
         shift_q <= rx_byte[6:0];
      end
   end

   // Reset leaves the machine waiting for an address byte
   always_ff @(posedge i_scl or negedge link_rstn) begin
      if (!link_rstn) begin
         st_q <= ST_ADDR;
         ack_q <= 1'b0;
         hi_q <= HI_RST;
         tx_q <= TX_RST;
      end else if (ack_slot) begin
         ack_q <= 1'b0;
         // High in the slot ends the operation
         if (i_sda) begin
            st_q <= ST_IGNORE;
         end else if (st_q == ST_RDATA) begin
            tx_q <= mem_q[mem_addr_q];
         end
      end else if (byte_end) begin
         case (st_q)
            ST_ADDR: begin
               // Acknowledge on match, else go quiet
               ack_q <= addr_match;
               // Direction bit picks read or write
               if (!addr_match) begin
                  st_q <= ST_IGNORE;
               end else if (rx_byte[0]) begin
                  st_q <= ST_RDATA;
               end else begin
                  st_q <= ST_MHI;
               end
            end
            ST_MHI: begin
               hi_q <= rx_byte[4:0];
               ack_q <= 1'b1;
               st_q <= ST_MLO;
            end
            ST_MLO: begin
               ack_q <= 1'b1;
               st_q <= ST_WDATA;
            end
            ST_WDATA: begin
               ack_q <= !wp_s_q;
            end
            default: begin
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address latch and array; latch survives start and stop

   // Load, then step with wrap at the top
   always_ff @(posedge i_scl or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_addr_q <= ADDR_RST;
      end else if (load_addr) begin
         mem_addr_q <= {hi_q, rx_byte};
      end else if (inc_addr) begin
         mem_addr_q <= mem_addr_q + ADDR_STEP;
      end
   end

   always_ff @(posedge i_scl) begin
      if (wr_en) begin
         mem_q[mem_addr_q] <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain driver, updated on the falling edge

   logic drive_q;
   wire drive_d;

   assign tx_pos = BIT_LAST - cnt_q;
   assign tx_bit = tx_q[tx_pos[2:0]];
   // Ack slot drives only the acknowledge; read bytes release it
   assign drive_d = ack_slot ? ack_q : ((st_q == ST_RDATA) && !tx_bit);

   // Change only on the falling edge
   always_ff @(negedge i_scl or negedge link_rstn) begin
      if (!link_rstn) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
      end
   end

   // Only the data line is ever pulled
   assign o_sda = 1'b0;
   assign o_sda_oe = drive_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   addr_ack_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (st_q == ST_ADDR && byte_end && addr_match) |=> ack_q && ack_slot ##1 !ack_q)
      else $error("matching address not acknowledged");

   addr_miss_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (st_q == ST_ADDR && byte_end && !addr_match) |=> (st_q == ST_IGNORE) [*4])
      else $error("mismatched address not ignored");

   wp_block_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (st_q == ST_WDATA && byte_end && wp_s_q) |=> !ack_q && $stable(mem_addr_q))
      else $error("protected write acknowledged or counted");

   addr_step_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (st_q == ST_WDATA && byte_end && !wp_s_q) |=> mem_addr_q == $past(mem_addr_q) + ADDR_STEP)
      else $error("address did not step after write");

   addr_load_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (st_q == ST_MLO && byte_end) |=> mem_addr_q == {$past(hi_q), $past(rx_byte)})
      else $error("address latch wrong after low byte");

   nack_end_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      (ack_slot && i_sda) |=> st_q == ST_IGNORE && cnt_q == BIT_FIRST)
      else $error("no-acknowledge did not end operation");

   drive_only_a: assert property (
      @(posedge i_scl) disable iff (!link_rstn)
      o_sda_oe |-> (ack_slot ? ack_q : st_q == ST_RDATA))
      else $error("data line driven outside ack or read");

   start_rst_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      start_det |=> !cond_rstn_q ##1 cond_rstn_q)
      else $error("start did not reset link side");

   stop_rst_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      stop_det |=> !cond_rstn_q)
      else $error("stop did not abort operation");

   read_sel_c: cover property (
      @(posedge i_scl) disable iff (!link_rstn)
      st_q == ST_ADDR && byte_end && addr_match && rx_byte[0]);

   write_ok_c: cover property (
      @(posedge i_scl) disable iff (!link_rstn)
      wr_en);

   read_more_c: cover property (
      @(posedge i_scl) disable iff (!link_rstn)
      st_q == ST_RDATA && ack_slot && !i_sda);

   start_c: cover property (
      @(posedge i_clk) disable iff (!i_rstn)
      start_det);

endmodule : nvm_top

// File: nvm_master.sv
// Behavioural two-wire bus master that faces the memory slave.
// Assumes the bench resolves the data line with a pull-up and feeds i_sda.
`timescale 1ns/1ps

module nvm_master (
   output logic o_scl,
   output logic o_sda_oe,
   input wire logic i_sda
);

   ////////////////////////////////////////////////////////////////////////////////
   // Master owns clock, idle high
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Data moves only while clock low; 100 ns low keeps both 50 ns margins
   task automatic bit_xfer(input logic v, output logic s);
      #50 o_sda_oe = ~v;
      #50 o_scl = 1'b1;
      s = i_sda;
      #25 o_scl = 1'b0;
   endtask : bit_xfer

   // Start before each operation; offset keeps edges off the system clock
   task automatic start_cond();
      #3;
      if (!o_scl) begin
         #50 o_sda_oe = 1'b0;
         #50 o_scl = 1'b1;
      end
      #200 o_sda_oe = 1'b1;
      #200 o_scl = 1'b0;
   endtask : start_cond

   // Stop only while master owns the data line
   task automatic stop_cond();
      #50 o_sda_oe = 1'b1;
      #50 o_scl = 1'b1;
      #200 o_sda_oe = 1'b0;
      #200;
   endtask : stop_cond

   // Most significant bit first, ninth slot released
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask : send_byte

   // Caller withholds the acknowledge on the last byte
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, s);
         b[i] = s;
      end
      bit_xfer(~ack, s);
   endtask : recv_byte

endmodule : nvm_master

// File: tb.sv
// Self-checking bench for the two-wire memory slave against a byte model.
// Assumes the master model owns the bus and the data line has a pull-up.
`timescale 1ns/1ps

module tb
   import nvm_pkg::*;
;

   // Device type code; value is arbitrary
   localparam logic [3:0] DEV_CODE = 4'h6;
   logic i_clk, i_rstn, scl, m_oe, d_sda, d_oe, wp;
   logic [2:0] cs;
   int fails = 0;
   int cmp_count = 0;
   int cur = 0;
   int unsigned seed = 13;
   logic [7:0] mem [MEM_WORDS];
   wire sda = ~m_oe & ~(d_oe & ~d_sda);

   nvm_top #(.DEV_TYPE(DEV_CODE)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl),
      .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe), .i_chip_select_pins(cs),
      .i_write_protect(wp));
   nvm_master m (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      #4;
      forever #12.5 i_clk = ~i_clk;
   end

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk_ack(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %b got %b", n, e, g);
      end
   endtask : chk_ack

   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk_byte

   task automatic stop_test();
      $display("TB: compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////////
   task automatic set_addr(input logic [12:0] a);
      logic k;
      m.start_cond();
      m.send_byte({DEV_CODE, cs, 1'b0}, k);
      chk_ack("sel_ack", 1'b1, k);
      m.send_byte({3'h0, a[12:8]}, k);
      chk_ack("hi_ack", 1'b1, k);
      m.send_byte(a[7:0], k);
      chk_ack("lo_ack", 1'b1, k);
      cur = a;
   endtask : set_addr

   // Model steps only on accepted bytes, so a refused byte leaves cur alone
   task automatic wr_bytes(input int n, input logic prot);
      logic k;
      logic [7:0] d;
      repeat (n) begin
         d = 8'(rnd());
         m.send_byte(d, k);
         chk_ack("data_ack", ~prot, k);
         if (!prot) begin
            mem[cur] = d;
            cur = (cur + 1) % MEM_WORDS;
         end
      end
   endtask : wr_bytes

   task automatic rd_bytes(input int n);
      logic k;
      logic [7:0] d;
      m.start_cond();
      m.send_byte({DEV_CODE, cs, 1'b1}, k);
      chk_ack("rd_sel", 1'b1, k);
      for (int i = 0; i < n; i++) begin
         m.recv_byte(i < n - 1, d);
         chk_byte("rd_data", mem[cur], d);
         cur = (cur + 1) % MEM_WORDS;
      end
      m.recv_byte(1'b0, d);
      chk_byte("released", 8'hFF, d);
      m.stop_cond();
   endtask : rd_bytes

   task automatic wrong_sel(input logic [7:0] b);
      logic k;
      m.start_cond();
      m.send_byte(b, k);
      chk_ack("sel_nack", 1'b0, k);
      m.send_byte({DEV_CODE, cs, 1'b0}, k);
      chk_ack("quiet", 1'b0, k);
      m.stop_cond();
   endtask : wrong_sel

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // The run needs about 5000 cycles, so a hang is caught well inside budget
      repeat (20000) @(posedge i_clk);
      fails++;
      $display("MISMATCH watchdog exp done got hang");
      stop_test();
   end

   initial begin
      logic [12:0] a;
      logic s;
      i_rstn = 1'b0;
      cs = 3'h0;
      wp = 1'b0;
      repeat (3) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (4) @(posedge i_clk);
      cs <= 3'(rnd());
      @(posedge i_clk);
      // Wrap across the top location, then selective read back
      set_addr(13'h1FFE);
      wr_bytes(3, 1'b0);
      m.stop_cond();
      set_addr(13'h1FFE);
      rd_bytes(3);
      for (int t = 0; t < 3; t++) begin
         @(posedge i_clk);
         cs <= 3'(rnd());
         a = 13'(rnd());
         set_addr(a);
         wr_bytes(4, 1'b0);
         m.stop_cond();
         set_addr(a);
         rd_bytes(4);
      end
      // Protected write leaves data and counter, checked by current read
      @(posedge i_clk);
      wp <= 1'b1;
      set_addr(a);
      wr_bytes(2, 1'b1);
      m.stop_cond();
      @(posedge i_clk);
      wp <= 1'b0;
      rd_bytes(2);
      wrong_sel({DEV_CODE, ~cs, 1'b0});
      wrong_sel({~DEV_CODE, cs, 1'b0});
      // Half a data byte then stop or start must not write
      for (int t = 0; t < 2; t++) begin
         set_addr(a);
         repeat (4) m.bit_xfer(1'(rnd()), s);
         if (t == 1) m.start_cond();
         m.stop_cond();
         rd_bytes(1);
      end
      // Reset in mid-run clears the latch; the array keeps its contents
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (4) @(posedge i_clk);
      cur = ADDR_RST;
      rd_bytes(1);
      stop_test();
   end

endmodule : tb
